/* logic/electrode_scan_configuration.sv */
/*
  electrode scan configuration: run/stop control, scan sequencing,
  per-channel charge time selection, auto-configuration hand-off and
  baseline start-up for a 12-input capacitive front end plus one
  combined proximity channel.
  assumes the measurement engine and the auto-configuration search engine
  are logic on the same clock; the register port is the serial bus slave.
  the engine itself combines the inputs that the proximity field selects;
  this block only decides when the combined channel is measured.
*/
// What this block does
// - a nonzero per-channel three-bit charge time is used, a zero one falls back to global.
// - each charge time register holds a lower channel in D2..D0 and the next in D6..D4.
// - with auto-configuration on, entering run first runs a search and stores its times.
// - with skip-time-search set the search never writes the per-channel charge times.
// - lock code 00 keeps baseline, 01 stops tracking, 10 loads high five bits, 11 all ten.
// - proximity select 00 off, 01 inputs 0-1, 10 inputs 0-3, 11 all twelve inputs.
// - input count n enables inputs 0..n-1, 0000 none and 11xx all twelve.
// - after reset the run configuration register is 0x00 and the block is stopped.
// - a nonzero proximity or count field starts run mode at once, and scanning after any auto-configuration search.
// - both fields zero means stop mode with no measurement.
// - run and stop may be switched at any moment by rewriting the run configuration.
// - a scan measures proximity first, then inputs in ascending order.
// - scans repeat at the selected sample interval while running.
// - disabled channels are skipped and take no scan time or charging.
// - with lock code 10 each channel's baseline is loaded from its first measurement.
// - global charge time code 000 disables charging, code n gives 2^(n-2) us.
// - a scan longer than the interval stretches the sample period to the scan time.
`timescale 1ns/100ps
module electrode_scan_configuration #(
  parameter int BASE_CYCLES = scan_cfg_pkg::BASE_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        meas_done_i,
  input  wire logic [9:0]  meas_data_i,
  input  wire logic        acfg_wr_i,
  input  wire logic [3:0]  acfg_chan_i,
  input  wire logic [2:0]  acfg_time_i,
  input  wire logic        acfg_done_i,
  output logic             meas_start_o,
  output logic      [3:0]  meas_chan_o,
  output logic      [2:0]  meas_time_o,
  output logic             acfg_start_o,
  output logic             acfg_skip_time_o,
  output logic             run_o,
  output logic             track_en_o,
  output logic             baseline_load_o,
  output logic      [3:0]  baseline_chan_o,
  output logic      [9:0]  baseline_value_o
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [4:0] {
    ST_STOP = 5'b00001,
    ST_ACFG = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_NEXT = 5'b01000,
    ST_MEAS = 5'b10000
  } phase_e;

  typedef struct packed {
    logic [7:0]      run_cfg;
    logic [7:0]      glob_cfg;
    logic [7:0]      acfg_ctl0;
    logic [7:0]      acfg_ctl1;
    logic [6:0][7:0] ctime;
    phase_e          phase;
    logic [3:0]      pos;
    logic [31:0]     tmr;
    logic            due;
    logic [12:0]     fresh;
    logic [7:0]      rdata;
    logic            mstart;
    logic [3:0]      mchan;
    logic [2:0]      mtime;
    logic            astart;
    logic            bload;
    logic [3:0]      bchan;
    logic [9:0]      bval;
    logic            run;
    logic            track;
    logic            skip;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ****************************************
  // helpers
  // ****************************************
  // enable test for a channel, proximity is channel 12
  function automatic logic chan_on(input logic [7:0] cfg, input logic [3:0] ch);
    logic [3:0] cnt;
    cnt = cfg[scan_cfg_pkg::COUNT_LSB +: 4];
    // counts above twelve act as all twelve inputs
    if (cnt > scan_cfg_pkg::INPUTS) begin
      cnt = scan_cfg_pkg::INPUTS;
    end
    if (ch == scan_cfg_pkg::CH_PROX) begin
      chan_on = (cfg[scan_cfg_pkg::PROX_LSB +: 2] != 2'h0);
    end else begin
      chan_on = (ch < cnt);
    end
  endfunction

  // scan position 0 is proximity, position k is input k-1
  function automatic logic [3:0] pos_chan(input logic [3:0] p);
    pos_chan = (p == 4'h0) ? scan_cfg_pkg::CH_PROX : 4'(p - 4'h1);
  endfunction

  // first enabled position at or after p, none gives the marker
  function automatic logic [3:0] next_pos(input logic [7:0] cfg, input logic [3:0] p);
    next_pos = scan_cfg_pkg::POS_NONE;
    for (int k = 12; k >= 0; k--) begin
      if (4'(k) >= p && chan_on(cfg, pos_chan(4'(k)))) begin
        next_pos = 4'(k);
      end
    end
  endfunction

  // effective charge time for a channel
  function automatic logic [2:0] eff_time(input state_s st, input logic [3:0] ch);
    logic [7:0] r;
    logic [2:0] f;
    r = st.ctime[ch[3:1]];
    f = ch[0] ? r[scan_cfg_pkg::PAIR_HI_LSB +: 3] : r[2:0];
    eff_time = (f != 3'h0) ? f :
               st.glob_cfg[scan_cfg_pkg::GTIME_LSB +: 3];
  endfunction

  // sample interval length in cycles, 2^n base periods
  // codes 0..7 give 1 to 128 base periods, well inside 32 bits
  function automatic logic [31:0] interval(input logic [7:0] g);
    interval = 32'(BASE_CYCLES) << g[scan_cfg_pkg::INTERVAL_LSB +: 3];
  endfunction

  // offset falls in the per-channel charge time block
  function automatic logic time_reg(input logic [7:0] a);
    time_reg = (a >= scan_cfg_pkg::OFS_TIME_FIRST) && (a <= scan_cfg_pkg::OFS_TIME_LAST);
  endfunction

  logic       running;
  logic       go_run;
  logic [3:0] tidx;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    // pulses fall back low unless a branch raises them
    s_d.mstart = 1'b0;
    s_d.astart = 1'b0;
    s_d.bload  = 1'b0;
    tidx = 4'(reg_addr_i - scan_cfg_pkg::OFS_TIME_FIRST);

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        scan_cfg_pkg::OFS_RUN_CONFIG: s_d.run_cfg = reg_wdata_i;
        scan_cfg_pkg::OFS_GLOBAL_CFG: s_d.glob_cfg = reg_wdata_i;
        scan_cfg_pkg::OFS_ACFG_CTL0: s_d.acfg_ctl0 = reg_wdata_i;
        scan_cfg_pkg::OFS_ACFG_CTL1: s_d.acfg_ctl1 = reg_wdata_i;
        default: begin
          if (time_reg(reg_addr_i)) begin
            s_d.ctime[tidx[2:0]] = reg_wdata_i & scan_cfg_pkg::TIME_WMASK;
          end
        end
      endcase
    end

    // register reads, unmapped offsets read zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        scan_cfg_pkg::OFS_RUN_CONFIG: s_d.rdata = s_q.run_cfg;
        scan_cfg_pkg::OFS_GLOBAL_CFG: s_d.rdata = s_q.glob_cfg;
        scan_cfg_pkg::OFS_ACFG_CTL0: s_d.rdata = s_q.acfg_ctl0;
        scan_cfg_pkg::OFS_ACFG_CTL1: s_d.rdata = s_q.acfg_ctl1;
        default: begin
          if (time_reg(reg_addr_i)) begin
            s_d.rdata = s_q.ctime[tidx[2:0]];
          end else begin
            s_d.rdata = 8'h00;
          end
        end
      endcase
    end

    // search results land in the per-channel time fields
    // placed after the host writes, so a search write wins the same cycle
    if (s_q.phase == ST_ACFG && acfg_wr_i &&
        !s_q.acfg_ctl1[scan_cfg_pkg::SKIP_TIME_BIT] &&
        acfg_chan_i <= scan_cfg_pkg::CH_PROX) begin
      if (acfg_chan_i[0]) begin
        s_d.ctime[acfg_chan_i[3:1]][scan_cfg_pkg::PAIR_HI_LSB +: 3] = acfg_time_i;
      end else begin
        s_d.ctime[acfg_chan_i[3:1]][2:0] = acfg_time_i;
      end
    end

    // interval timer runs freely while scanning, held at zero during the search
    // a long scan leaves due set, so the next scan follows it at once
    if (s_q.phase != ST_STOP && s_q.phase != ST_ACFG) begin
      if (s_q.tmr + 32'h1 >= interval(s_q.glob_cfg)) begin
        s_d.tmr = 32'h0;
        s_d.due = 1'b1;
      end else begin
        s_d.tmr = s_q.tmr + 32'h1;
      end
    end

    // sequencing
    case (s_q.phase)
      // leaving stop restarts the interval and re-arms the baseline loads
      ST_STOP: begin
        if (go_run) begin
          s_d.fresh = 13'h1FFF;
          s_d.tmr   = 32'h0;
          if (s_q.acfg_ctl0[scan_cfg_pkg::AUTO_EN_BIT]) begin
            s_d.phase  = ST_ACFG;
            s_d.astart = 1'b1;
          end else begin
            s_d.phase = ST_NEXT;
            s_d.pos   = 4'h0;
          end
        end
      end
      // search in progress, the first scan waits for its done pulse
      ST_ACFG: begin
        if (acfg_done_i) begin
          s_d.phase = ST_NEXT;
          s_d.pos   = 4'h0;
        end
      end
      // the edge that elapses the interval also starts the scan
      ST_WAIT: begin
        if (s_d.due) begin
          s_d.due   = 1'b0;
          s_d.phase = ST_NEXT;
          s_d.pos   = 4'h0;
        end
      end
      // choose the next enabled position, or idle until the interval ends
      ST_NEXT: begin
        if (next_pos(s_q.run_cfg, s_q.pos) == scan_cfg_pkg::POS_NONE) begin
          s_d.phase = ST_WAIT;
        end else begin
          s_d.pos    = next_pos(s_q.run_cfg, s_q.pos);
          s_d.mchan  = pos_chan(s_d.pos);
          s_d.mtime  = eff_time(s_q, s_d.mchan);
          s_d.mstart = 1'b1;
          s_d.phase  = ST_MEAS;
        end
      end
      // first result of each channel after run entry may seed its baseline
      ST_MEAS: begin
        if (meas_done_i) begin
          if (s_q.fresh[s_q.mchan]) begin
            s_d.fresh[s_q.mchan] = 1'b0;
            s_d.bchan = s_q.mchan;
            case (s_q.run_cfg[scan_cfg_pkg::LOCK_LSB +: 2])
              scan_cfg_pkg::LOCK_HIGH5: begin
                s_d.bload = 1'b1;
                s_d.bval  = {meas_data_i[9:5], 5'h00};
              end
              scan_cfg_pkg::LOCK_ALL10: begin
                s_d.bload = 1'b1;
                s_d.bval  = meas_data_i;
              end
              default: s_d.bload = 1'b0;
            endcase
          end
          s_d.pos   = 4'(s_q.pos + 4'h1);
          s_d.phase = ST_NEXT;
        end
      end
      default: s_d.phase = ST_STOP;
    endcase

    // stop wins at any moment, aborting a scan in flight
    if (!running && s_q.phase != ST_STOP) begin
      s_d.phase = ST_STOP;
      s_d.due   = 1'b0;
      s_d.tmr   = 32'h0;
      s_d.mstart = 1'b0;                                        // no start once stopped
    end

    // level outputs kept in flops so every port comes from a register
    s_d.run   = (s_d.phase != ST_STOP);
    s_d.track = (s_d.phase != ST_STOP) &&
                (s_d.run_cfg[scan_cfg_pkg::LOCK_LSB +: 2] != scan_cfg_pkg::LOCK_OFF);
    s_d.skip  = s_d.acfg_ctl1[scan_cfg_pkg::SKIP_TIME_BIT];
  end

  // run is decided from the configuration as it stands
  // go_run names the decision taken in stop; both read the same fields
  assign running = (s_q.run_cfg[scan_cfg_pkg::PROX_LSB +: 2] != 2'h0) ||
                   (s_q.run_cfg[scan_cfg_pkg::COUNT_LSB +: 4] != 4'h0);
  assign go_run  = running;

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      // package reset values and the stop phase, everything else clears
      s_q           <= '0;
      s_q.run_cfg   <= scan_cfg_pkg::RST_RUN_CONFIG;
      s_q.glob_cfg  <= scan_cfg_pkg::RST_GLOBAL_CFG;
      s_q.acfg_ctl0 <= scan_cfg_pkg::RST_ACFG;
      s_q.acfg_ctl1 <= scan_cfg_pkg::RST_ACFG;
      s_q.ctime     <= {scan_cfg_pkg::TIME_REGS{scan_cfg_pkg::RST_TIME}};
      s_q.phase     <= ST_STOP;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs, all straight from the state register
  // ****************************************
  assign reg_rdata_o      = s_q.rdata;
  assign meas_start_o     = s_q.mstart;
  assign meas_chan_o      = s_q.mchan;
  assign meas_time_o      = s_q.mtime;
  assign acfg_start_o     = s_q.astart;
  assign acfg_skip_time_o = s_q.skip;
  assign run_o            = s_q.run;
  assign track_en_o       = s_q.track;
  assign baseline_load_o  = s_q.bload;
  assign baseline_chan_o  = s_q.bchan;
  assign baseline_value_o = s_q.bval;

endmodule

/* common/scan_cfg_pkg.sv */
/*
  constants for the electrode scan configuration block: register offsets,
  field positions, reset values, channel numbering and timing counts.
  assumes a register port that carries 8-bit offsets and 8-bit data.
*/
package scan_cfg_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_GLOBAL_CFG  = 8'h5D;
  localparam logic [7:0] OFS_RUN_CONFIG  = 8'h5E;
  localparam logic [7:0] OFS_TIME_FIRST  = 8'h6C;
  localparam logic [7:0] OFS_TIME_LAST   = 8'h72;
  localparam logic [7:0] OFS_ACFG_CTL0   = 8'h7B;
  localparam logic [7:0] OFS_ACFG_CTL1   = 8'h7C;
  // ****************************************
  // reset values and write mask
  // ****************************************
  localparam logic [7:0] RST_RUN_CONFIG  = 8'h00;
  localparam logic [7:0] RST_GLOBAL_CFG  = 8'h24;
  localparam logic [7:0] RST_TIME        = 8'h00;
  localparam logic [7:0] RST_ACFG        = 8'h00;
  localparam logic [7:0] TIME_WMASK      = 8'h77;
  // ****************************************
  // field positions
  // ****************************************
  localparam int LOCK_LSB        = 6;
  localparam int PROX_LSB        = 4;
  localparam int COUNT_LSB       = 0;
  localparam int GTIME_LSB       = 0;
  localparam int INTERVAL_LSB    = 3;
  localparam int PAIR_HI_LSB     = 4;
  localparam int AUTO_EN_BIT     = 0;
  localparam int SKIP_TIME_BIT   = 7;
  // ****************************************
  // codes and channel numbering
  // ****************************************
  localparam logic [1:0] LOCK_KEEP     = 2'h0;
  localparam logic [1:0] LOCK_OFF      = 2'h1;
  localparam logic [1:0] LOCK_HIGH5    = 2'h2;
  localparam logic [1:0] LOCK_ALL10    = 2'h3;
  localparam logic [3:0] CH_PROX       = 4'hC;
  localparam logic [3:0] POS_NONE      = 4'hF;
  localparam logic [3:0] INPUTS        = 4'hC;
  localparam int         TIME_REGS     = 7;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ         = 250;
  localparam int BASE_MS         = 1;
  localparam int BASE_CYCLES     = BASE_MS * CLK_MHZ * 1000;
endpackage

/* verif/electrode_scan_configuration_props.sv */
/*
  checker for run/stop control and scan handshake outputs.
  assumes it is bound onto the scan configuration top, one clock.
*/
`timescale 1ns/100ps
module electrode_scan_configuration_props #(
  parameter int BASE_CYCLES = 20
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       meas_done_i,
  input wire logic       meas_start_o,
  input wire logic [3:0] meas_chan_o,
  input wire logic       acfg_start_o,
  input wire logic       run_o,
  input wire logic       baseline_load_o,
  input wire logic [3:0] baseline_chan_o
);
  // ********************
  // properties
  // ********************
  logic cfg_wr;
  // write to the run configuration register
  assign cfg_wr = ce_i && reg_wr_i && (reg_addr_i == scan_cfg_pkg::OFS_RUN_CONFIG);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // the register updates on the write edge, the phase one edge later
  a_run_on_write: assert property (cfg_wr && reg_wdata_i[5:0] != 6'h00 |=> ##1 run_o)
    else $error("run not entered after nonzero config");
  a_stop_on_write: assert property (cfg_wr && reg_wdata_i[5:0] == 6'h00 |=> ##1 !run_o)
    else $error("stop not entered after zero config");
  a_run_held: assert property (!cfg_wr ##1 !cfg_wr |=> $stable(run_o))
    else $error("run changed without a config write");
  a_start_in_run: assert property (meas_start_o |-> run_o)
    else $error("measurement started while stopped");
  a_start_pulse: assert property (meas_start_o |=> !meas_start_o)
    else $error("start longer than one cycle");
  a_chan_range: assert property (meas_start_o |-> meas_chan_o <= 4'hC)
    else $error("start on a channel that does not exist");
  a_load_follows: assert property (baseline_load_o |-> $past(meas_done_i)
    && baseline_chan_o == meas_chan_o && !meas_start_o)
    else $error("baseline load not tied to a measurement");
  a_acfg_pulse: assert property (acfg_start_o |-> run_o ##1 !acfg_start_o)
    else $error("search start malformed");
  a_reset_idle: assert property ($rose(rst_n_i) |-> !run_o && !meas_start_o)
    else $error("not idle after reset");
endmodule
bind electrode_scan_configuration electrode_scan_configuration_props #(
  .BASE_CYCLES(BASE_CYCLES)
) u_props (.ref_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .meas_done_i, .meas_start_o, .meas_chan_o, .acfg_start_o, .run_o,
  .baseline_load_o, .baseline_chan_o);

/* verif/scan_engine_model.sv */
/*
  behavioural measurement engine and charge search engine.
  assumes the scan block on the same clock; answers after dly_i cycles.
*/
`timescale 1ns/100ps
module scan_engine_model (
  input  wire logic       ref_clk_i,
  input  wire logic [5:0] dly_i,
  input  wire logic       meas_start_o,
  input  wire logic [3:0] meas_chan_o,
  input  wire logic       acfg_start_o,
  output logic            meas_done_i,
  output logic      [9:0] meas_data_i,
  output logic            acfg_wr_i,
  output logic      [3:0] acfg_chan_i,
  output logic      [2:0] acfg_time_i,
  output logic            acfg_done_i
);
  // ********************
  // engines
  // ********************
  initial begin
    {meas_done_i, acfg_wr_i, acfg_done_i} = 3'h0;
    {meas_data_i, acfg_chan_i, acfg_time_i} = 17'h0;
  end
  // measurement: data carries the channel number, scrambled when idle
  always @(posedge ref_clk_i) begin
    if (meas_start_o === 1'b1) begin
      repeat (dly_i) @(posedge ref_clk_i);
      #1 meas_done_i = 1'b1;
      meas_data_i = {meas_chan_o, 6'h35};
      @(posedge ref_clk_i);
      #1 meas_done_i = 1'b0;
      meas_data_i = ~meas_data_i;
    end
  end
  // search: proposes time code 5 for all thirteen channels
  always @(posedge ref_clk_i) begin
    if (acfg_start_o === 1'b1) begin
      for (int k = 0; k < 13; k++) begin
        #1 acfg_wr_i = 1'b1;
        acfg_chan_i = 4'(k);
        acfg_time_i = 3'h5;
        @(posedge ref_clk_i);
      end
      #1 acfg_wr_i = 1'b0;
      acfg_time_i = 3'h2;
      acfg_done_i = 1'b1;
      @(posedge ref_clk_i);
      #1 acfg_done_i = 1'b0;
    end
  end
endmodule

/* verif/electrode_scan_configuration_test.sv */
/*
  self-checking bench: register tasks, scan runs with expected order.
  assumes the design and the engine model; base interval of 20 cycles.
*/
`timescale 1ns/100ps
module electrode_scan_configuration_test;
  logic       ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, meas_done_i, acfg_wr_i, acfg_done_i;
  logic       meas_start_o, acfg_start_o, acfg_skip_time_o, run_o, track_en_o, baseline_load_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [9:0] meas_data_i, baseline_value_o;
  logic [3:0] acfg_chan_i, meas_chan_o, baseline_chan_o;
  logic [2:0] acfg_time_i, meas_time_o, g, tim[13];
  logic [5:0] dly;
  logic [6:0] starts[$];
  logic [13:0] loads[$];
  int         fails = 0, compares = 0, cyc = 0, acnt = 0, t0[$];
  // ********************
  // instances and clock
  // ********************
  electrode_scan_configuration #(.BASE_CYCLES(20)) dut (.ref_clk_i, .rst_n_i, .ce_i(1'b1),
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .meas_done_i, .meas_data_i,
    .acfg_wr_i, .acfg_chan_i, .acfg_time_i, .acfg_done_i, .meas_start_o, .meas_chan_o,
    .meas_time_o, .acfg_start_o, .acfg_skip_time_o, .run_o, .track_en_o, .baseline_load_o,
    .baseline_chan_o, .baseline_value_o);
  scan_engine_model pm (.ref_clk_i, .dly_i(dly), .meas_start_o, .meas_chan_o, .acfg_start_o,
    .meas_done_i, .meas_data_i, .acfg_wr_i, .acfg_chan_i, .acfg_time_i, .acfg_done_i);
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // monitor of starts, loads and search pulses; cycle ceiling
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (meas_start_o === 1'b1) starts.push_back({meas_chan_o, meas_time_o});
    if (meas_start_o === 1'b1 && meas_chan_o === 4'h0) t0.push_back(cyc);
    if (baseline_load_o === 1'b1) loads.push_back({baseline_chan_o, baseline_value_o});
    if (acfg_start_o === 1'b1) acnt <= acnt + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_wr_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge ref_clk_i);
    #1 reg_rd_i = 1'b0;
    @(posedge ref_clk_i);
    #1 chk(reg_rdata_o, exp);
  endtask
  function automatic logic [2:0] exp_t(input logic [3:0] c);
    return (tim[c] != 3'h0) ? tim[c] : g;
  endfunction
  // run two scans with config cfg, check order, times, loads, period, then stop
  task automatic scan(input logic [7:0] cfg, input int per);
    int n;
    int sz;
    logic [3:0] ch[$];
    n = (cfg[3:2] == 2'b11) ? 12 : int'(cfg[3:0]);
    if (cfg[5:4] != 2'b00) ch.push_back(4'hC);
    for (int i = 0; i < n; i++) ch.push_back(4'(i));
    starts.delete();
    loads.delete();
    t0.delete();
    wr(8'h5E, cfg);
    chk(run_o, 1'b1);
    chk(track_en_o, cfg[7:6] != 2'b01);
    for (int i = 0; i < 5000 && starts.size() < 2 * ch.size(); i++) @(posedge ref_clk_i);
    #1;
    for (int i = 0; i < 2 * ch.size(); i++)
      chk(starts[i], {ch[i % ch.size()], exp_t(ch[i % ch.size()])});
    chk(16'(loads.size()), cfg[7] ? 16'(ch.size()) : 16'h0);
    foreach (loads[i]) chk(loads[i], {ch[i], ch[i], cfg[6] ? 6'h35 : 6'h20});
    if (per > 0) chk(16'(t0[1] - t0[0]), 16'(per));
    if (per < 0) chk(16'(t0[1] - t0[0] > -per), 16'h1);
    wr(8'h5E, {cfg[7:6], 6'h00});
    chk(run_o, 1'b0);
    sz = starts.size();
    repeat (60) @(posedge ref_clk_i);
    #1 chk(16'(starts.size() - sz), 16'h0);
  endtask
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ********************
  // sequence
  // ********************
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i} = 3'h0;
    {reg_addr_i, reg_wdata_i} = 16'h0;
    dly = 6'h02;
    g = 3'h4;
    tim = '{default: 3'h0};
    repeat (6) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    chk(run_o, 1'b0);
    rdc(8'h5E, 8'h00);
    rdc(8'h90, 8'h00);
    wr(8'h6C, 8'hFF);
    rdc(8'h6C, 8'h77);
    wr(8'h6C, 8'h50);
    wr(8'h72, 8'h06);
    wr(8'h5D, 8'h03);
    tim[1] = 3'h5;
    tim[12] = 3'h6;
    g = 3'h3;
    scan(8'hD2, 20);
    scan(8'h81, 20);
    wr(8'h5D, 8'h0B);
    scan(8'h01, 40);
    dly = 6'h0C;
    scan(8'h4C, -40);
    dly = 6'h02;
    scan(8'h70, 0);
    scan(8'hAF, -40);
    wr(8'h7B, 8'h01);
    wr(8'h7C, 8'h80);
    chk(acfg_skip_time_o, 1'b1);
    scan(8'h01, 0);
    rdc(8'h6C, 8'h50);
    wr(8'h7C, 8'h00);
    tim = '{default: 3'h5};
    scan(8'h01, 0);
    rdc(8'h6C, 8'h55);
    chk(16'(acnt), 16'h2);
    results();
  end
endmodule
